// ===== src/power_status_params.svh
`ifndef POWER_STATUS_PARAMS_SVH
`define POWER_STATUS_PARAMS_SVH

// register offsets on the configuration port
`define PROT_STAT_ADDR 8'h03
`define REG_THM_STAT_ADDR 8'h04
`define BAT_CONV_STAT_ADDR 8'h05
`define LIN_EVT_ADDR 8'h07
`define CONV_EVT_ADDR 8'h08

// protection_status fields
`define PROT_CHG_THM_BIT 7
`define PROT_LIN_THM_BIT 5
`define PROT_LIN2_UVLO_BIT 4
`define PROT_LIN1_UVLO_BIT 3

// regulation_thermal_status fields
`define RT_BB_FAULT_BIT 7
`define RT_HARV_CMP_BIT 6
`define RT_SYS_LIM_BIT 5
`define RT_IN_LIM_BIT 4
`define RT_STEP_BIT 3
`define RT_BUCK1_THM_BIT 2
`define RT_BUCK2_THM_BIT 1
`define RT_BUCK3_THM_BIT 0

// battery_converter_status fields
`define BC_BAT_GOOD_BIT 7
`define BC_BAT_REG_BIT 6
`define BC_ALT_FAULT_BIT 5

// change-event bits sit at the same positions as their status bits
`define LIN_EVT_MASK 8'hB8
`define CONV_EVT_MASK 8'hFF

`define STATUS_RESET 8'h00
`define UNMAPPED_READ 8'h00
`define SYNC_LATENCY 2'h3

`endif

// ===== src/power_status_pkg.sv
package power_status_pkg;

   // one field per analog monitor, all asynchronous to sys_clk
   typedef struct packed {
      logic chargerThermalShutdown;
      logic linearSwitchThermalShutdown;
      logic linear2Lockout;
      logic linear1Lockout;
      logic buckBoostFault;
      logic harvesterBatteryCompare;
      logic systemRailLimitActive;
      logic inputVoltageLimitActive;
      logic stepChargeActive;
      logic buck1ThermalShutdown;
      logic buck2ThermalShutdown;
      logic buck3ThermalShutdown;
      logic batteryAboveLockout;
      logic batteryRegulationReached;
      logic converterFaultAlt;
      logic chargerInputPresent;
      logic chargerInputOvervoltage;
      logic chargerInputInRange;
   } monitor_t;

endpackage

// ===== src/status_sync_if.sv
`timescale 1ns/1ns
interface status_sync_if;
   power_status_pkg::monitor_t rawMon;
   power_status_pkg::monitor_t syncMon;

   modport sync (input rawMon, output syncMon);
   modport core (output rawMon, input syncMon);
endinterface

// ===== src/monitor_sync.sv
`timescale 1ns/1ns
module monitor_sync (
   input wire logic sys_clk, // system clock
   input wire logic rst, // synchronous reset, active high
   status_sync_if.sync mon // raw monitors in, synchronised out
);
   power_status_pkg::monitor_t stage1_r;
   power_status_pkg::monitor_t stage2_r;

   // stage1 feeds only stage2, so metastability never reaches logic
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stage1_r <= '0;
         stage2_r <= '0;
      end else begin
         stage1_r <= mon.rawMon;
         stage2_r <= stage1_r;
      end
   end

   assign mon.syncMon = stage2_r;
endmodule

// ===== src/power_status_register_bank.sv
// Operation
// - protection bit 7 shows input limiter and charger thermal shutdown.
// - protection bit 5 shows any linear regulator or load switch overheated.
// - protection bits 4 and 3 show lockout of linear regulator 2 and 1.
// - regulation bit 5 shows charge current cut to hold system rail.
// - regulation bit 4 shows input limiter cut to hold charger input.
// - regulation bit 3 shows step-charge current reduction active.
// - regulation bit 2 shows buck 1 thermal shutdown.
// - regulation bits 1 and 0 show buck 2 and buck 3 thermal shutdown.
// - battery bit 7 set when battery above lockout or charger input absent.
// - charger input valid only when present and in range; qualifies charger flags.
// - every change of a protection or regulation flag sets its event bit; battery flags have none.
`timescale 1ns/1ns
`include "power_status_params.svh"
module power_status_register_bank (
   input wire logic sys_clk, // system clock, 250 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic chargerThermalShutdown, // limiter/charger overheated
   input wire logic linearSwitchThermalShutdown, // linear or switch overheated
   input wire logic linear2Lockout, // linear regulator 2 undervoltage
   input wire logic linear1Lockout, // linear regulator 1 undervoltage
   input wire logic buckBoostFault, // buck-boost fault
   input wire logic harvesterBatteryCompare, // battery above harvester level
   input wire logic systemRailLimitActive, // charge current being reduced
   input wire logic inputVoltageLimitActive, // input limiter being reduced
   input wire logic stepChargeActive, // step-charge reduction active
   input wire logic buck1ThermalShutdown, // buck 1 overheated
   input wire logic buck2ThermalShutdown, // buck 2 overheated
   input wire logic buck3ThermalShutdown, // buck 3 overheated
   input wire logic batteryAboveLockout, // battery above lockout level
   input wire logic batteryRegulationReached, // battery at regulation level
   input wire logic converterFaultAlt, // second converter fault
   input wire logic chargerInputPresent, // charger input voltage present
   input wire logic chargerInputOvervoltage, // charger input overvoltage
   input wire logic chargerInputInRange, // charger input inside valid range
   input wire logic [7:0] regAddr, // register offset
   input wire logic regRdEn, // read strobe, one cycle
   input wire logic regWrEn, // write strobe, one cycle
   input wire logic [7:0] regWrData, // write data
   output logic [7:0] regRdData, // read data
   output logic regRdValid, // read data valid, one cycle
   output logic chargerInputValid, // qualified charger input
   output logic eventPending // any change event set
);
   status_sync_if monIf ();
   power_status_pkg::monitor_t m;

   logic [7:0] prot_r, prot_nxt;
   logic [7:0] regThm_r, regThm_nxt;
   logic [7:0] batConv_r, batConv_nxt;
   logic [7:0] linEvt_r, linEvt_nxt;
   logic [7:0] convEvt_r, convEvt_nxt;
   logic [7:0] regRdData_r;
   logic regRdValid_r;
   logic chargerInputValid_r, chargerInputValid_nxt;
   logic eventPending_r;
   logic [1:0] age_r;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers

   assign monIf.rawMon = '{
      chargerThermalShutdown: chargerThermalShutdown,
      linearSwitchThermalShutdown: linearSwitchThermalShutdown,
      linear2Lockout: linear2Lockout,
      linear1Lockout: linear1Lockout,
      buckBoostFault: buckBoostFault,
      harvesterBatteryCompare: harvesterBatteryCompare,
      systemRailLimitActive: systemRailLimitActive,
      inputVoltageLimitActive: inputVoltageLimitActive,
      stepChargeActive: stepChargeActive,
      buck1ThermalShutdown: buck1ThermalShutdown,
      buck2ThermalShutdown: buck2ThermalShutdown,
      buck3ThermalShutdown: buck3ThermalShutdown,
      batteryAboveLockout: batteryAboveLockout,
      batteryRegulationReached: batteryRegulationReached,
      converterFaultAlt: converterFaultAlt,
      chargerInputPresent: chargerInputPresent,
      chargerInputOvervoltage: chargerInputOvervoltage,
      chargerInputInRange: chargerInputInRange};

   monitor_sync u_monitor_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .mon(monIf.sync)
   );

   assign m = monIf.syncMon;

   ////////////////////////////////////////////////////////////////////////////
   // status composition

   // charger flags are forced low when the input is not valid, so the host
   // never sees stale regulation state from an absent charger
   always_comb begin
      chargerInputValid_nxt = m.chargerInputPresent & m.chargerInputInRange
         & ~m.chargerInputOvervoltage;
      prot_nxt = `STATUS_RESET;
      prot_nxt[`PROT_CHG_THM_BIT] = m.chargerThermalShutdown;
      prot_nxt[`PROT_LIN_THM_BIT] = m.linearSwitchThermalShutdown;
      prot_nxt[`PROT_LIN2_UVLO_BIT] = m.linear2Lockout;
      prot_nxt[`PROT_LIN1_UVLO_BIT] = m.linear1Lockout;
      regThm_nxt = `STATUS_RESET;
      regThm_nxt[`RT_BB_FAULT_BIT] = m.buckBoostFault;
      regThm_nxt[`RT_HARV_CMP_BIT] = m.harvesterBatteryCompare;
      regThm_nxt[`RT_SYS_LIM_BIT] = m.systemRailLimitActive
         & chargerInputValid_nxt;
      regThm_nxt[`RT_IN_LIM_BIT] = m.inputVoltageLimitActive
         & chargerInputValid_nxt;
      regThm_nxt[`RT_STEP_BIT] = m.stepChargeActive & chargerInputValid_nxt;
      regThm_nxt[`RT_BUCK1_THM_BIT] = m.buck1ThermalShutdown;
      regThm_nxt[`RT_BUCK2_THM_BIT] = m.buck2ThermalShutdown;
      regThm_nxt[`RT_BUCK3_THM_BIT] = m.buck3ThermalShutdown;
      batConv_nxt = `STATUS_RESET;
      batConv_nxt[`BC_BAT_GOOD_BIT] = m.batteryAboveLockout
         | ~m.chargerInputPresent;
      batConv_nxt[`BC_BAT_REG_BIT] = m.batteryRegulationReached & chargerInputValid_nxt
         & ~m.systemRailLimitActive;
      batConv_nxt[`BC_ALT_FAULT_BIT] = m.converterFaultAlt;
   end

   // status bits are live: no write path reaches them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prot_r <= `STATUS_RESET;
         regThm_r <= `STATUS_RESET;
         batConv_r <= `STATUS_RESET;
         chargerInputValid_r <= 1'b0;
      end else begin
         prot_r <= prot_nxt;
         regThm_r <= regThm_nxt;
         batConv_r <= batConv_nxt;
         chargerInputValid_r <= chargerInputValid_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // change events, write one to clear; a set in the clearing cycle wins

   function automatic logic [7:0] evtUpdate(input logic [7:0] cur,
                                            input logic [7:0] nxtStat,
                                            input logic [7:0] oldStat,
                                            input logic [7:0] mask,
                                            input logic [7:0] clr);
      logic [7:0] setBits;
      setBits = (nxtStat ^ oldStat) & mask;
      return (cur & ~clr & mask) | setBits;
   endfunction

   always_comb begin
      linEvt_nxt = evtUpdate(linEvt_r, prot_nxt, prot_r, `LIN_EVT_MASK,
         (regWrEn && regAddr == `LIN_EVT_ADDR) ? regWrData : 8'h00);
      convEvt_nxt = evtUpdate(convEvt_r, regThm_nxt, regThm_r, `CONV_EVT_MASK,
         (regWrEn && regAddr == `CONV_EVT_ADDR) ? regWrData : 8'h00);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         linEvt_r <= `STATUS_RESET;
         convEvt_r <= `STATUS_RESET;
         eventPending_r <= 1'b0;
      end else begin
         linEvt_r <= linEvt_nxt;
         convEvt_r <= convEvt_nxt;
         eventPending_r <= |{linEvt_nxt, convEvt_nxt};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port

   function automatic logic [7:0] readByte(input logic [7:0] addr);
      case (addr)
         `PROT_STAT_ADDR: readByte = prot_r;
         `REG_THM_STAT_ADDR: readByte = regThm_r;
         `BAT_CONV_STAT_ADDR: readByte = batConv_r;
         `LIN_EVT_ADDR: readByte = linEvt_r;
         `CONV_EVT_ADDR: readByte = convEvt_r;
         default: readByte = `UNMAPPED_READ;
      endcase
   endfunction

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         regRdData_r <= `UNMAPPED_READ;
         regRdValid_r <= 1'b0;
      end else begin
         regRdValid_r <= regRdEn;
         if (regRdEn) begin
            regRdData_r <= readByte(regAddr);
         end
      end
   end

   assign regRdData = regRdData_r;
   assign regRdValid = regRdValid_r;
   assign chargerInputValid = chargerInputValid_r;
   assign eventPending = eventPending_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks: age_r tells when the pipeline holds no reset-era values

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         age_r <= 2'h0;
      end else if (age_r != `SYNC_LATENCY) begin
         age_r <= age_r + 2'h1;
      end
   end

   chg_thermal_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      age_r == `SYNC_LATENCY |-> prot_r[7] == $past(chargerThermalShutdown, 3))
      else $error("charger thermal bit wrong");

   lin_thermal_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      age_r == `SYNC_LATENCY |-> prot_r[5] == $past(linearSwitchThermalShutdown, 3))
      else $error("linear thermal bit wrong");

   lockout_bits_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      age_r == `SYNC_LATENCY |->
      prot_r[4:3] == {$past(linear2Lockout, 3), $past(linear1Lockout, 3)})
      else $error("lockout bits wrong");

   charger_gate_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      age_r == `SYNC_LATENCY |-> regThm_r[5] == ($past(systemRailLimitActive, 3)
      & $past(chargerInputPresent, 3) & $past(chargerInputInRange, 3)
      & ~$past(chargerInputOvervoltage, 3)))
      else $error("charger rail limit bit wrong");

   input_limit_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      age_r == `SYNC_LATENCY && chargerInputValid_r |->
      regThm_r[4] == $past(inputVoltageLimitActive, 3) &&
      regThm_r[3] == $past(stepChargeActive, 3))
      else $error("limiter or step bit wrong");

   buck_thermal_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      age_r == `SYNC_LATENCY |-> regThm_r[2:0] == {$past(buck1ThermalShutdown, 3),
      $past(buck2ThermalShutdown, 3), $past(buck3ThermalShutdown, 3)})
      else $error("buck thermal bits wrong");

   battery_good_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      age_r == `SYNC_LATENCY |-> batConv_r[7] ==
      ($past(batteryAboveLockout, 3) | ~$past(chargerInputPresent, 3)))
      else $error("battery good bit wrong");

   input_valid_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      age_r == `SYNC_LATENCY |-> chargerInputValid_r ==
      ($past(chargerInputPresent, 3) & $past(chargerInputInRange, 3)
      & ~$past(chargerInputOvervoltage, 3)))
      else $error("charger input valid wrong");

   event_set_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      (!$changed(prot_r[3]) || linEvt_r[3]) && (!$changed(regThm_r[2]) || convEvt_r[2]))
      else $error("change did not set event");

   event_hold_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      linEvt_r[3] && !(regWrEn && regAddr == `LIN_EVT_ADDR && regWrData[3])
      |=> linEvt_r[3])
      else $error("event lost without clear");

   fault_bits_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      age_r == `SYNC_LATENCY |-> regThm_r[7] == $past(buckBoostFault, 3) &&
      batConv_r[5] == $past(converterFaultAlt, 3))
      else $error("converter fault bit wrong");

   read_only_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      regRdEn && regAddr == `BAT_CONV_STAT_ADDR |=>
      regRdValid_r && regRdData_r == $past(batConv_r) && regRdData_r[4:0] == 5'h00
      && prot_r[6] == 1'b0 && prot_r[2:0] == 3'h0)
      else $error("status read wrong");
endmodule

// ===== verif/status_host.sv
`timescale 1ns/1ns
// host on the register port: one request at a time, each strobe lasts one cycle
module status_host (
   input wire logic sys_clk, // system clock
   input wire logic [7:0] regRdData, // read data from the bank
   input wire logic regRdValid, // read answer pulse
   output logic [7:0] regAddr, // register offset
   output logic regRdEn, // read strobe
   output logic regWrEn, // write strobe
   output logic [7:0] regWrData // write data
);
   initial begin
      regAddr = 8'h00;
      regRdEn = 1'h0;
      regWrEn = 1'h0;
      regWrData = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // address, and on writes the data, are inverted once the strobe drops, so late sampling shows
   task automatic readReg(input logic [7:0] addr, output logic [7:0] data,
                          output logic seen);
      @(posedge sys_clk);
      regAddr <= addr;
      regRdEn <= 1'h1;
      @(posedge sys_clk);
      regRdEn <= 1'h0;
      regAddr <= ~addr;
      @(posedge sys_clk);
      seen = regRdValid;
      data = regRdData;
   endtask

   task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      regAddr <= addr;
      regWrData <= data;
      regWrEn <= 1'h1;
      @(posedge sys_clk);
      regWrEn <= 1'h0;
      regAddr <= ~addr;
      regWrData <= ~data;
   endtask
endmodule

// ===== verif/tb_power_status_register_bank.sv
`timescale 1ns/1ns
module tb_power_status_register_bank;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   power_status_pkg::monitor_t mon = '0;
   logic [7:0] regAddr, regWrData, regRdData, rdData;
   logic regRdEn, regWrEn, regRdValid, chargerInputValid, eventPending, seen;
   int failures = 0;
   int numChecks = 0;
   // monitor levels, then 0x03, 0x04, 0x05 and the charger input valid level
   logic [42:0] rows [0:15] = '{
      {18'h0_0000, 8'h00, 8'h00, 8'h80, 1'h0},
      {18'h2_0000, 8'h80, 8'h00, 8'h80, 1'h0},
      {18'h1_0000, 8'h20, 8'h00, 8'h80, 1'h0},
      {18'h0_8000, 8'h10, 8'h00, 8'h80, 1'h0},
      {18'h0_4000, 8'h08, 8'h00, 8'h80, 1'h0},
      {18'h0_2000, 8'h00, 8'h80, 8'h80, 1'h0},
      {18'h0_1000, 8'h00, 8'h40, 8'h80, 1'h0},
      {18'h0_0100, 8'h00, 8'h04, 8'h80, 1'h0},
      {18'h0_0080, 8'h00, 8'h02, 8'h80, 1'h0},
      {18'h0_0040, 8'h00, 8'h01, 8'h80, 1'h0},
      {18'h0_0008, 8'h00, 8'h00, 8'hA0, 1'h0},
      {18'h0_0E05, 8'h00, 8'h38, 8'h00, 1'h1},
      {18'h0_0E04, 8'h00, 8'h00, 8'h00, 1'h0},
      {18'h0_0E07, 8'h00, 8'h00, 8'h00, 1'h0},
      {18'h0_0035, 8'h00, 8'h00, 8'hC0, 1'h1},
      {18'h0_0835, 8'h00, 8'h20, 8'h80, 1'h1}};

   always #2 sys_clk = ~sys_clk;

   power_status_register_bank u_power_status_register_bank (
      .sys_clk(sys_clk),
      .rst(rst),
      .chargerThermalShutdown(mon.chargerThermalShutdown),
      .linearSwitchThermalShutdown(mon.linearSwitchThermalShutdown),
      .linear2Lockout(mon.linear2Lockout),
      .linear1Lockout(mon.linear1Lockout),
      .buckBoostFault(mon.buckBoostFault),
      .harvesterBatteryCompare(mon.harvesterBatteryCompare),
      .systemRailLimitActive(mon.systemRailLimitActive),
      .inputVoltageLimitActive(mon.inputVoltageLimitActive),
      .stepChargeActive(mon.stepChargeActive),
      .buck1ThermalShutdown(mon.buck1ThermalShutdown),
      .buck2ThermalShutdown(mon.buck2ThermalShutdown),
      .buck3ThermalShutdown(mon.buck3ThermalShutdown),
      .batteryAboveLockout(mon.batteryAboveLockout),
      .batteryRegulationReached(mon.batteryRegulationReached),
      .converterFaultAlt(mon.converterFaultAlt),
      .chargerInputPresent(mon.chargerInputPresent),
      .chargerInputOvervoltage(mon.chargerInputOvervoltage),
      .chargerInputInRange(mon.chargerInputInRange),
      .regAddr(regAddr),
      .regRdEn(regRdEn),
      .regWrEn(regWrEn),
      .regWrData(regWrData),
      .regRdData(regRdData),
      .regRdValid(regRdValid),
      .chargerInputValid(chargerInputValid),
      .eventPending(eventPending)
   );

   status_host u_status_host (
      .sys_clk(sys_clk),
      .regRdData(regRdData),
      .regRdValid(regRdValid),
      .regAddr(regAddr),
      .regRdEn(regRdEn),
      .regWrEn(regWrEn),
      .regWrData(regWrData)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      numChecks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask

   task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp);
      u_status_host.readReg(addr, rdData, seen);
      check("read answer", 8'h01, {7'h00, seen});
      check($sformatf("register %h", addr), exp, rdData);
   endtask

   // monitors need two sync flops plus the status register before they show
   task automatic settle();
      repeat (5) @(posedge sys_clk);
   endtask

   task automatic giveVerdict();
      $display("checks %0d failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge sys_clk);
      failures++;
      giveVerdict();
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'h0;
      for (int i = 0; i < 16; i++) begin
         mon <= rows[i][42:25];
         settle();
         readCheck(8'h03, rows[i][24:17]);
         readCheck(8'h04, rows[i][16:9]);
         readCheck(8'h05, rows[i][8:1]);
         check("input valid", {7'h00, rows[i][0]}, {7'h00, chargerInputValid});
      end
      // change events: clear everything, then one lockout edge
      mon <= '0;
      settle();
      u_status_host.writeReg(8'h07, 8'hFF);
      u_status_host.writeReg(8'h08, 8'hFF);
      @(posedge sys_clk);
      check("pending", 8'h00, {7'h00, eventPending});
      mon.linear1Lockout <= 1'h1;
      settle();
      check("pending", 8'h01, {7'h00, eventPending});
      readCheck(8'h07, 8'h08);
      readCheck(8'h08, 8'h00);
      for (int a = 3; a < 6; a++) begin
         u_status_host.writeReg(a[7:0], 8'hFF);
      end
      u_status_host.writeReg(8'h20, 8'hFF);
      readCheck(8'h03, 8'h08);
      readCheck(8'h04, 8'h00);
      readCheck(8'h05, 8'h80);
      readCheck(8'h20, 8'h00);
      u_status_host.writeReg(8'h07, 8'h08);
      @(posedge sys_clk);
      check("pending", 8'h00, {7'h00, eventPending});
      readCheck(8'h07, 8'h00);
      mon.buck1ThermalShutdown <= 1'h1;
      settle();
      readCheck(8'h08, 8'h04);
      // the clear lands on the edge where the status bit falls: the set must win
      mon.buck1ThermalShutdown <= 1'h0;
      @(posedge sys_clk);
      u_status_host.writeReg(8'h08, 8'h04);
      readCheck(8'h08, 8'h04);
      // second reset with monitors high: outputs stay low until release
      @(posedge sys_clk);
      mon <= 18'h0_4005;
      rst <= 1'h1;
      repeat (4) @(posedge sys_clk);
      check("input valid", 8'h00, {7'h00, chargerInputValid});
      check("pending", 8'h00, {7'h00, eventPending});
      check("read answer", 8'h00, {7'h00, regRdValid});
      rst <= 1'h0;
      settle();
      check("input valid", 8'h01, {7'h00, chargerInputValid});
      check("pending", 8'h01, {7'h00, eventPending});
      readCheck(8'h07, 8'h08);
      readCheck(8'h03, 8'h08);
      giveVerdict();
   end
endmodule
